/* core/ibp_pkg.sv */
// Shared types and constants for the intra block predictor.
// Assumes neighbour samples are 8-bit and arrive from reconstruction storage.
package ibp_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] IBP_REG_CTRL = 8'h00;
  localparam logic [7:0] IBP_REG_STATUS = 8'h04;
  // Control field positions and reset value
  localparam int IBP_CTRL_INTRA_ONLY = 0;
  localparam int IBP_CTRL_LMODE_LSB = 1;
  localparam int IBP_CTRL_CMODE_LSB = 3;
  localparam logic [4:0] IBP_CTRL_RESET = 5'h04;
  // Status field positions
  localparam int IBP_ST_BUSY = 0;
  localparam int IBP_ST_AV_TOP = 1;
  localparam int IBP_ST_AV_LEFT = 2;
  localparam int IBP_ST_AV_CORNER = 3;
  localparam int IBP_ST_MODE_ERR = 4;

  // Block sizes and plane centres
  localparam int IBP_LUMA_N = 16;
  localparam int IBP_CHROMA_N = 8;
  localparam int IBP_LUMA_CTR = 7;
  localparam int IBP_CHROMA_CTR = 3;
  // DC rounding and shifts
  localparam int IBP_LDC_BOTH_RND = 16;
  localparam int IBP_LDC_BOTH_SH = 5;
  localparam int IBP_LDC_ONE_RND = 8;
  localparam int IBP_LDC_ONE_SH = 4;
  localparam int IBP_CDC_BOTH_RND = 8;
  localparam int IBP_CDC_BOTH_SH = 4;
  localparam int IBP_CDC_ONE_RND = 4;
  localparam int IBP_CDC_ONE_SH = 3;
  localparam logic [7:0] IBP_DC_NONE = 8'h80;
  // Plane gradient and output constants
  localparam int IBP_A_MUL = 16;
  localparam int IBP_LB_MUL = 5;
  localparam int IBP_LB_RND = 32;
  localparam int IBP_LB_SH = 6;
  localparam int IBP_CB_MUL = 17;
  localparam int IBP_CB_RND = 16;
  localparam int IBP_CB_SH = 5;
  localparam int IBP_PL_RND = 16;
  localparam int IBP_PL_SH = 5;
  localparam int IBP_SMP_MAX = 255;
  localparam int IBP_BLOCK_SAMPLES = 384;

  typedef enum logic [1:0] {
    IBP_VERT = 2'h0, IBP_HORZ = 2'h1, IBP_DC = 2'h2, IBP_PLANE = 2'h3
  } ibp_mode_t;

  typedef enum logic [3:0] {
    IBP_IDLE = 4'h1, IBP_LUMA = 4'h2, IBP_CB = 4'h4, IBP_CR = 4'h8
  } ibp_fsm_t;

  typedef enum logic [1:0] {
    IBP_C_LUMA = 2'h0, IBP_C_CB = 2'h1, IBP_C_CR = 2'h2
  } ibp_comp_t;

  // Neighbours of one block; chroma uses entries 0..7 only
  typedef struct packed {
    logic [15:0][7:0] top;
    logic [15:0][7:0] left;
    logic [7:0] corner;
  } ibp_nb_t;

  // Where a neighbour side lies, as known to reconstruction control
  typedef struct packed {
    logic in_pic_slice;
    logic intra;
  } ibp_side_t;

  typedef struct packed {
    ibp_side_t top;
    ibp_side_t left;
    ibp_side_t corner;
  } ibp_avail_in_t;

  typedef struct packed {
    logic signed [19:0] a;
    logic signed [19:0] b;
    logic signed [19:0] c;
  } ibp_plane_t;

  // One predicted sample with its position
  typedef struct packed {
    logic valid;
    ibp_comp_t comp;
    logic [3:0] x;
    logic [3:0] y;
    logic [7:0] sample;
  } ibp_pred_t;

  typedef struct packed {
    ibp_fsm_t fsm;
    logic intra_only;
    ibp_mode_t lmode;
    ibp_mode_t cmode;
    ibp_mode_t lmode_eff;
    ibp_mode_t cmode_eff;
    ibp_nb_t [2:0] nb;
    logic av_top;
    logic av_left;
    logic av_corner;
    logic mode_err;
    logic [3:0] x;
    logic [3:0] y;
    ibp_pred_t pred;
    ibp_mode_t pred_mode;
    logic done;
    logic [31:0] rdata;
  } ibp_state_t;

endpackage

/* core/ibp_predictor.sv */
// Intra predictor for one 16x16 luma block and two 8x8 chroma blocks.
// Assumes a start pulse with neighbours and side flags valid in that cycle.
`timescale 1ns/100ps

// Contract
// - Outside picture or slice means unavailable
// - Intra-only flag hides non-intra neighbours
// - Luma uses 33 neighbours, corner plane only
// - Luma vertical needs top; copies columns
// - Luma horizontal needs left; copies rows
// - Luma DC both: (sum32+16)>>5
// - Luma DC left only: (sum16+8)>>4
// - Luma DC top only: (sum16+8)>>4
// - DC with no neighbours gives 128
// - Luma plane output clamped, centre seven
// - Luma gradients (5*H+32)>>6 over eight taps
// - One chroma mode, independent of luma
// - Chroma uses 17 neighbours, corner plane only
// - Chroma vertical needs top; copies columns
// - Chroma horizontal needs left; copies rows
// - Chroma DC both: (sum16+8)>>4
// - Chroma DC top only: (sum8+4)>>3
// - Chroma plane centre three, (17*H+16)>>5
// - Chroma H and V over four taps
module ibp_predictor
  import ibp_pkg::*;
(
  input wire logic clk_i,               // System clock, 100 MHz
  input wire logic rst_n_i,             // Synchronous reset, active low
  input wire logic [7:0] addr_i,        // Register byte address
  input wire logic [31:0] wdata_i,      // Register write data
  input wire logic wr_i,                // Register write strobe
  input wire logic rd_i,                // Register read strobe
  output logic [31:0] rdata_o,          // Read data, cycle after rd_i
  input wire logic start_i,             // Begin one macroblock
  input wire ibp_avail_in_t avail_in_i, // Side position and intra flags
  input wire ibp_nb_t luma_nb_i,        // Luma neighbours
  input wire ibp_nb_t cb_nb_i,          // First chroma neighbours
  input wire ibp_nb_t cr_nb_i,          // Second chroma neighbours
  output ibp_pred_t pred_o,             // Predicted sample stream
  output logic busy_o,                  // Block in progress
  output logic done_o                   // Pulse with the last sample
);

  ibp_state_t s;      // Registered state
  ibp_state_t next_s; // Next state
  logic start_go;     // Start accepted this cycle

  // Side is usable when inside the picture and slice, and intra if required
  function automatic logic side_ok(input ibp_side_t sd, input logic intra_only);
    side_ok = sd.in_pic_slice && (!intra_only || sd.intra);
  endfunction

  // Demote a requested mode to DC when its neighbours are missing
  function automatic ibp_mode_t legal_mode(input ibp_mode_t m, input logic at,
                                           input logic al, input logic ac);
    legal_mode = m;
    case (m)
      IBP_VERT: if (!at) legal_mode = IBP_DC;
      IBP_HORZ: if (!al) legal_mode = IBP_DC;
      IBP_PLANE: if (!(at && al && ac)) legal_mode = IBP_DC;
      default: legal_mode = m;
    endcase
  endfunction

  // DC value for one block; sums cover 16 or 8 taps per side
  function automatic logic [7:0] dc_value(input ibp_nb_t n, input logic chroma,
                                          input logic at, input logic al);
    int st;
    int sl;
    int cnt;
    st = 0;
    sl = 0;
    cnt = chroma ? IBP_CHROMA_N : IBP_LUMA_N;
    for (int i = 0; i < IBP_LUMA_N; i++) begin
      if (i < cnt) begin
        st = st + int'(n.top[i]);
        sl = sl + int'(n.left[i]);
      end
    end
    if (at && al) begin
      // Both sides
      dc_value = chroma ? 8'((st + sl + IBP_CDC_BOTH_RND) >> IBP_CDC_BOTH_SH)
                        : 8'((st + sl + IBP_LDC_BOTH_RND) >> IBP_LDC_BOTH_SH);
    end else if (al) begin
      // Left column only
      dc_value = chroma ? 8'((sl + IBP_CDC_ONE_RND) >> IBP_CDC_ONE_SH)
                        : 8'((sl + IBP_LDC_ONE_RND) >> IBP_LDC_ONE_SH);
    end else if (at) begin
      // Top row only
      dc_value = chroma ? 8'((st + IBP_CDC_ONE_RND) >> IBP_CDC_ONE_SH)
                        : 8'((st + IBP_LDC_ONE_RND) >> IBP_LDC_ONE_SH);
    end else begin
      dc_value = IBP_DC_NONE;
    end
  endfunction

  // Plane parameters; the farthest lower tap is the corner sample
  function automatic ibp_plane_t plane_params(input ibp_nb_t n, input logic chroma);
    int ctr;
    int h;
    int v;
    int lo_t;
    int lo_l;
    ibp_plane_t p;
    ctr = chroma ? IBP_CHROMA_CTR : IBP_LUMA_CTR;
    h = 0;
    v = 0;
    for (int k = 1; k <= IBP_CHROMA_N; k++) begin
      if (k <= ctr + 1) begin
        lo_t = (ctr - k < 0) ? int'(n.corner) : int'(n.top[ctr - k]);
        lo_l = (ctr - k < 0) ? int'(n.corner) : int'(n.left[ctr - k]);
        h = h + k * (int'(n.top[ctr + k]) - lo_t);
        v = v + k * (int'(n.left[ctr + k]) - lo_l);
      end
    end
    p.a = 20'(IBP_A_MUL * (int'(n.left[2 * ctr + 1]) + int'(n.top[2 * ctr + 1])));
    if (chroma) begin
      p.b = 20'((IBP_CB_MUL * h + IBP_CB_RND) >>> IBP_CB_SH);
      p.c = 20'((IBP_CB_MUL * v + IBP_CB_RND) >>> IBP_CB_SH);
    end else begin
      p.b = 20'((IBP_LB_MUL * h + IBP_LB_RND) >>> IBP_LB_SH);
      p.c = 20'((IBP_LB_MUL * v + IBP_LB_RND) >>> IBP_LB_SH);
    end
    plane_params = p;
  endfunction

  // Plane sample at (x, y) after the range clamp
  function automatic logic [7:0] plane_sample(input ibp_plane_t p, input logic chroma,
                                              input logic [3:0] x, input logic [3:0] y);
    int ctr;
    int val;
    ctr = chroma ? IBP_CHROMA_CTR : IBP_LUMA_CTR;
    val = int'(p.a) + int'(p.b) * (int'(x) - ctr) + int'(p.c) * (int'(y) - ctr);
    val = (val + IBP_PL_RND) >>> IBP_PL_SH;
    // Sample range clamp keeps results inside the 8-bit sample range
    if (val < 0) begin
      plane_sample = 8'h00;
    end else if (val > IBP_SMP_MAX) begin
      plane_sample = 8'hFF;
    end else begin
      plane_sample = 8'(val);
    end
  endfunction

  // One predicted sample for the given block, mode and position
  function automatic logic [7:0] pred_sample(input ibp_nb_t n, input logic chroma,
                                             input ibp_mode_t m, input logic at,
                                             input logic al, input logic [3:0] x,
                                             input logic [3:0] y);
    case (m)
      IBP_VERT: pred_sample = n.top[x];
      IBP_HORZ: pred_sample = n.left[y];
      IBP_PLANE: pred_sample = plane_sample(plane_params(n, chroma), chroma, x, y);
      default: pred_sample = dc_value(n, chroma, at, al);
    endcase
  endfunction

  assign start_go = (s.fsm == IBP_IDLE) && start_i;

  // Next-state logic: register port, start capture and sample walk
  always_comb begin
    logic chroma;
    logic [3:0] last;
    next_s = s;
    chroma = (s.fsm != IBP_LUMA);
    last = chroma ? 4'(IBP_CHROMA_N - 1) : 4'(IBP_LUMA_N - 1);
    next_s.done = 1'b0;
    next_s.pred.valid = 1'b0;
    next_s.rdata = 32'h0000_0000;
    // Control write steers availability policy and requested modes
    if (wr_i && (addr_i == IBP_REG_CTRL)) begin
      next_s.intra_only = wdata_i[IBP_CTRL_INTRA_ONLY];
      next_s.lmode = ibp_mode_t'(wdata_i[IBP_CTRL_LMODE_LSB +: 2]);
      next_s.cmode = ibp_mode_t'(wdata_i[IBP_CTRL_CMODE_LSB +: 2]);
    end
    // Reads answer one cycle later; unmapped addresses read zero
    if (rd_i) begin
      case (addr_i)
        IBP_REG_CTRL: begin
          next_s.rdata[IBP_CTRL_INTRA_ONLY] = s.intra_only;
          next_s.rdata[IBP_CTRL_LMODE_LSB +: 2] = s.lmode;
          next_s.rdata[IBP_CTRL_CMODE_LSB +: 2] = s.cmode;
        end
        IBP_REG_STATUS: begin
          next_s.rdata[IBP_ST_BUSY] = (s.fsm != IBP_IDLE);
          next_s.rdata[IBP_ST_AV_TOP] = s.av_top;
          next_s.rdata[IBP_ST_AV_LEFT] = s.av_left;
          next_s.rdata[IBP_ST_AV_CORNER] = s.av_corner;
          next_s.rdata[IBP_ST_MODE_ERR] = s.mode_err;
        end
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    case (s.fsm)
      IBP_IDLE: begin
        // Capture neighbours so the feeder may move on after start
        if (start_i) begin
          next_s.nb[IBP_C_LUMA] = luma_nb_i;
          next_s.nb[IBP_C_CB] = cb_nb_i;
          next_s.nb[IBP_C_CR] = cr_nb_i;
          next_s.av_top = side_ok(avail_in_i.top, s.intra_only);
          next_s.av_left = side_ok(avail_in_i.left, s.intra_only);
          next_s.av_corner = side_ok(avail_in_i.corner, s.intra_only);
          next_s.lmode_eff = legal_mode(s.lmode, next_s.av_top, next_s.av_left,
                                        next_s.av_corner);
          // One chroma mode for both chroma blocks, separate from luma
          next_s.cmode_eff = legal_mode(s.cmode, next_s.av_top, next_s.av_left,
                                        next_s.av_corner);
          // Record a request the neighbours cannot support
          next_s.mode_err = (next_s.lmode_eff != s.lmode) ||
                            (next_s.cmode_eff != s.cmode);
          next_s.x = 4'h0;
          next_s.y = 4'h0;
          next_s.fsm = IBP_LUMA;
        end
      end
      IBP_LUMA, IBP_CB, IBP_CR: begin
        // Emit one sample per clock, raster order within each block
        next_s.pred.valid = 1'b1;
        next_s.pred.x = s.x;
        next_s.pred.y = s.y;
        next_s.pred_mode = chroma ? s.cmode_eff : s.lmode_eff;
        case (s.fsm)
          IBP_CB: next_s.pred.comp = IBP_C_CB;
          IBP_CR: next_s.pred.comp = IBP_C_CR;
          default: next_s.pred.comp = IBP_C_LUMA;
        endcase
        next_s.pred.sample = pred_sample(s.nb[next_s.pred.comp], chroma,
                                         next_s.pred_mode, s.av_top, s.av_left,
                                         s.x, s.y);
        if (s.x == last) begin
          next_s.x = 4'h0;
          if (s.y == last) begin
            // Block finished: step to the next component
            next_s.y = 4'h0;
            case (s.fsm)
              IBP_LUMA: next_s.fsm = IBP_CB;
              IBP_CB: next_s.fsm = IBP_CR;
              default: begin
                next_s.fsm = IBP_IDLE;
                next_s.done = 1'b1;
              end
            endcase
          end else begin
            next_s.y = s.y + 4'h1;
          end
        end else begin
          next_s.x = s.x + 4'h1;
        end
      end
      default: next_s.fsm = IBP_IDLE;
    endcase
  end

  // State register; reset leaves luma DC and chroma vertical requested and the walk idle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.fsm <= IBP_IDLE;
      s.intra_only <= IBP_CTRL_RESET[IBP_CTRL_INTRA_ONLY];
      s.lmode <= ibp_mode_t'(IBP_CTRL_RESET[IBP_CTRL_LMODE_LSB +: 2]);
      s.cmode <= ibp_mode_t'(IBP_CTRL_RESET[IBP_CTRL_CMODE_LSB +: 2]);
    end else begin
      s <= next_s;
    end
  end

  assign pred_o = s.pred;
  assign rdata_o = s.rdata;
  assign done_o = s.done;
  assign busy_o = (s.fsm != IBP_IDLE);

  // Helper for checks: samples emitted since the last start
  logic [8:0] chk_cnt;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      chk_cnt <= 9'h000;
    end else if (start_go) begin
      chk_cnt <= 9'h000;
    end else if (s.pred.valid) begin
      chk_cnt <= chk_cnt + 9'h001;
    end
  end

  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_slice_edge: assert property (start_go && !avail_in_i.top.in_pic_slice |=> !s.av_top)
    else $error("Top side outside slice taken as available");
  a_intra_hide: assert property (start_go && s.intra_only && avail_in_i.left.in_pic_slice &&
                                 !avail_in_i.left.intra |=> !s.av_left)
    else $error("Non-intra left side used under intra-only policy");
  a_vert_copy: assert property (s.pred.valid && s.pred_mode == IBP_VERT |->
                                s.pred.sample == s.nb[s.pred.comp].top[s.pred.x] && s.av_top)
    else $error("Vertical sample differs from its top neighbour");
  a_horz_copy: assert property (s.pred.valid && s.pred_mode == IBP_HORZ |->
                                s.pred.sample == s.nb[s.pred.comp].left[s.pred.y] && s.av_left)
    else $error("Horizontal sample differs from its left neighbour");
  a_dc_none: assert property (s.pred.valid && s.pred_mode == IBP_DC && !s.av_top &&
                              !s.av_left |-> s.pred.sample == IBP_DC_NONE)
    else $error("DC without neighbours is not mid grey");
  a_plane_legal: assert property (s.pred.valid && s.pred_mode == IBP_PLANE |->
                                  s.av_top && s.av_left && s.av_corner)
    else $error("Plane sample produced without all neighbours");
  a_chroma_shared: assert property (s.pred.valid && s.pred.comp != IBP_C_LUMA |->
                                    s.pred_mode == s.cmode_eff)
    else $error("Chroma blocks used different modes");
  a_luma_first: assert property (start_go |=> (s.fsm == IBP_LUMA)[*8] ##0
                                 (s.pred.comp == IBP_C_LUMA))
    else $error("Luma walk did not start after start");
  a_block_count: assert property (s.done |-> chk_cnt == 9'(IBP_BLOCK_SAMPLES - 1))
    else $error("Macroblock did not emit all samples");

  c_luma_plane: cover property (s.pred.valid && s.pred.comp == IBP_C_LUMA &&
                                s.pred_mode == IBP_PLANE);
  c_dc_grey: cover property (s.pred.valid && s.pred_mode == IBP_DC && !s.av_top && !s.av_left);
  c_chroma_horz: cover property (s.pred.valid && s.pred.comp == IBP_C_CR &&
                                 s.pred_mode == IBP_HORZ);
  c_mode_demoted: cover property (s.mode_err && s.done);

endmodule // ibp_predictor

/* verification/ibp_recon_model.sv */
// Model of the reconstruction side: neighbour storage, side flags and the start pulse.
// Assumes the bench asks for a start with req_i, at times also while the predictor is busy.
`timescale 1ns/100ps
module ibp_recon_model
  import ibp_pkg::*;
(
  input wire logic clk_i,           // System clock
  input wire logic rst_n_i,         // Synchronous reset, active low
  input wire logic req_i,           // Bench asks for one macroblock
  input wire logic busy_i,          // Predictor has taken the neighbours
  input wire logic [7:0] base_i,    // Neighbour pattern base value
  input wire logic [7:0] step_i,    // Neighbour pattern slope
  input wire logic [5:0] avail_i,   // Top, left, corner: in slice, intra
  output logic start_o,             // One-cycle start pulse
  output ibp_avail_in_t avail_o,    // Side flags towards the predictor
  output ibp_nb_t luma_o,           // Luma neighbours
  output ibp_nb_t cb_o,             // First chroma neighbours
  output ibp_nb_t cr_o              // Second chroma neighbours
);
  ibp_nb_t nb [3]; // Clean neighbour sets, one per component

  // Ramps up along the top and down along the left so every mode gives distinct values
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      for (int i = 0; i < 16; i++) begin
        nb[c].top[i] = base_i + 8'(c * 80) + 8'(i) * step_i;
        nb[c].left[i] = base_i + 8'h40 + 8'(c * 80) - 8'(i) * step_i;
      end
      nb[c].corner = base_i + 8'h11 + 8'(c);
    end
  end

  // Storage moves on once the block is taken, so stale values are inverted
  assign luma_o = busy_i ? ~nb[0] : nb[0];
  assign cb_o = busy_i ? ~nb[1] : nb[1];
  assign cr_o = busy_i ? ~nb[2] : nb[2];
  assign avail_o = avail_i; // Position and intra flags per side

  // Start follows the request by one cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      start_o <= 1'b0;
    end else begin
      start_o <= req_i;
    end
  end
endmodule // ibp_recon_model

/* verification/tb.sv */
// Self-checking bench for the intra predictor: register tasks and full macroblock runs.
// Assumes the reconstruction model supplies neighbours and start; one 100 MHz clock.
`timescale 1ns/100ps
module tb;
  import ibp_pkg::*;
  logic clk_i; // Clock
  logic rst_n_i; // Reset, active low
  logic [7:0] addr; // Register address
  logic [31:0] wdata; // Register write data
  logic wr; // Write strobe
  logic rd; // Read strobe
  logic [31:0] rdata; // Read data
  logic req; // Start request to the model
  logic [7:0] base; // Pattern base
  logic [7:0] step; // Pattern slope
  logic [5:0] avail; // Side flags
  logic start; // Start pulse
  ibp_avail_in_t av_in; // Side flags at the predictor
  ibp_nb_t luma_nb; // Luma neighbours
  ibp_nb_t cb_nb; // First chroma neighbours
  ibp_nb_t cr_nb; // Second chroma neighbours
  ibp_pred_t pred; // Sample stream
  logic busy; // Busy level
  logic done; // Last sample pulse
  int n_mismatch; // Mismatches
  int n_checks; // Comparisons
  int cyc; // Cycle count for the hang limit
  logic [31:0] d; // Read result

  ibp_predictor dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .start_i(start), .avail_in_i(av_in),
    .luma_nb_i(luma_nb), .cb_nb_i(cb_nb), .cr_nb_i(cr_nb), .pred_o(pred),
    .busy_o(busy), .done_o(done));
  ibp_recon_model model_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .busy_i(busy),
    .base_i(base), .step_i(step), .avail_i(avail), .start_o(start), .avail_o(av_in),
    .luma_o(luma_nb), .cb_o(cb_nb), .cr_o(cr_nb));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard: all eleven runs need about 4400 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("[FAIL] %0t hang limit reached", $time);
      wrap_up;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // Mode actually used: an illegal request falls back to DC
  function automatic int eff(input int m, input logic at, input logic al, input logic ac);
    return ((m == 0 && !at) || (m == 1 && !al) || (m == 3 && !(at && al && ac))) ? 2 : m;
  endfunction

  // Neighbour fetch where index -1 is the shared corner
  function automatic int nbs(input ibp_nb_t nb, input int side, input int i);
    if (i < 0) return nb.corner;
    return side ? nb.left[i] : nb.top[i];
  endfunction

  function automatic logic [7:0] exp_smp(input ibp_nb_t nb, input int n, input int m,
      input logic at, input logic al, input int x, input int y);
    int st, sl, h, v, b, c, ct, p;
    ct = n / 2 - 1;
    st = 0;
    sl = 0;
    h = 0;
    v = 0;
    for (int i = 0; i < n; i++) begin
      st += nb.top[i];
      sl += nb.left[i];
    end
    for (int i = 1; i <= n / 2; i++) begin
      h += i * (nbs(nb, 0, ct + i) - nbs(nb, 0, ct - i));
      v += i * (nbs(nb, 1, ct + i) - nbs(nb, 1, ct - i));
    end
    case (m)
      0: return nb.top[x];
      1: return nb.left[y];
      2: begin
        if (at && al) return 8'((n == 16) ? (st + sl + 16) >> 5 : (st + sl + 8) >> 4);
        if (al) return 8'((n == 16) ? (sl + 8) >> 4 : (sl + 4) >> 3);
        if (at) return 8'((n == 16) ? (st + 8) >> 4 : (st + 4) >> 3);
        return 8'h80;
      end
      default: begin
        b = (n == 16) ? (5 * h + 32) >>> 6 : (17 * h + 16) >>> 5;
        c = (n == 16) ? (5 * v + 32) >>> 6 : (17 * v + 16) >>> 5;
        p = (16 * (nb.left[n - 1] + nb.top[n - 1]) + b * (x - ct) + c * (y - ct) + 16) >>> 5;
        return (p < 0) ? 8'h00 : (p > 255) ? 8'hFF : 8'(p);
      end
    endcase
  endfunction

  // One macroblock: set modes, start, check all 384 samples, then status
  task automatic run(input int lm, input int cm, input logic io, input logic [5:0] av,
      input logic [7:0] b0, input logic [7:0] s0, input logic poke);
    logic at, al, ac;
    int ml, mc, w, c, i, n;
    ibp_nb_t nb [3];
    at = av[5] && (!io || av[4]);
    al = av[3] && (!io || av[2]);
    ac = av[1] && (!io || av[0]);
    ml = eff(lm, at, al, ac);
    mc = eff(cm, at, al, ac);
    reg_wr(8'h00, {27'h0, 2'(cm), 2'(lm), io});
    base <= b0;
    step <= s0;
    avail <= av;
    @(posedge clk_i);
    req <= 1'b1;
    @(posedge clk_i);
    req <= 1'b0;
    #1 nb[0] = luma_nb;
    nb[1] = cb_nb;
    nb[2] = cr_nb;
    for (w = 0; w < 8 && pred.valid !== 1'b1; w++) begin
      @(posedge clk_i);
      #1;
    end
    // Start is taken one edge after this point, first sample two edges later
    chk(w, 2, "first sample latency");
    for (int k = 0; k < 384; k++) begin
      c = (k < 256) ? 0 : (k < 320) ? 1 : 2;
      i = (c == 0) ? k : (k - 256) % 64;
      n = (c == 0) ? 16 : 8;
      chk({pred.valid, pred.comp, pred.x, pred.y}, {1'b1, 2'(c), 4'(i % n), 4'(i / n)}, "pos");
      chk(pred.sample, exp_smp(nb[c], n, c ? mc : ml, at, al, i % n, i / n), "sample");
      chk(done, k == 383, "done");
      if (poke) req <= (k == 100);
      @(posedge clk_i);
      #1;
    end
    repeat (3) begin
      chk({busy, pred.valid}, 2'b00, "idle after block");
      @(posedge clk_i);
      #1;
    end
    reg_rd(8'h04, d);
    chk(d, {27'h0, (ml != lm) || (mc != cm), ac, al, at, 1'b0}, "status");
  endtask

  initial begin
    rst_n_i = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    req = 1'b0;
    base = 8'h00;
    step = 8'h00;
    avail = 6'h00;
    n_mismatch = 0;
    n_checks = 0;
    cyc = 0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1 chk({busy, done, pred}, 32'h0, "reset outputs");
    reg_rd(8'h00, d);
    chk(d, 32'h04, "ctrl reset");
    reg_rd(8'h04, d);
    chk(d, 32'h0, "status reset");
    reg_wr(8'h04, 32'h1F);
    reg_rd(8'h04, d);
    chk(d, 32'h0, "status read only");
    reg_wr(8'h40, 32'hFFFF_FFFF);
    reg_rd(8'h40, d);
    chk(d, 32'h0, "unmapped read");
    reg_rd(8'h00, d);
    chk(d, 32'h04, "ctrl kept");
    // Every luma mode against a different chroma mode, one with a start while busy
    for (int m = 0; m < 4; m++) run(m, 3 - m, 1'b0, 6'h3F, 8'(32 + m * 49), 8'(5 + m * 6), m == 1);
    run(2, 2, 1'b0, 6'h0F, 8'h30, 8'h07, 1'b0);
    run(2, 2, 1'b0, 6'h33, 8'h90, 8'h03, 1'b0);
    run(2, 2, 1'b0, 6'h00, 8'h50, 8'h09, 1'b0);
    run(0, 1, 1'b1, 6'h2F, 8'h70, 8'h04, 1'b0);
    run(0, 0, 1'b0, 6'h2F, 8'h70, 8'h04, 1'b0);
    run(3, 3, 1'b0, 6'h3C, 8'hA0, 8'h02, 1'b0);
    run(3, 3, 1'b0, 6'h3F, 8'h00, 8'h10, 1'b0);
    wrap_up;
  end
endmodule // tb
